// file: sai_stack_indirect.v
// Return stack and indirect address decode for the 8-bit core.
// Assumes the core issues one push, pop or indirect access per cycle, synchronous to clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "sai_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// How it works
// - Sixteen fifteen-bit stack entries, private storage
// - Option off: stack wraps, flags still set
// - Pointer write selects entry for top access
// - Calls, interrupts push; three returns pop
// - Push: increment then store; pop: read then decrement
// - Reset leaves stack empty, pointer 0x1F
// - Empty stack top reads zero or entry 0x0F
// - Option on: over/underflow reset device, flag
// - Indirect port accesses pointer's target address
// - Pointer at port: read zero, no write
// - Pointers sixteen bits from two bytes
// - 0x0000-0x1FFF maps to banked data
// - 0x2000-0x2FEF maps GENERAL_PURPOSE_RAM blocks consecutively
// - Unimplemented linear locations read zero
// - Common bytes excluded from linear region
// - Bit 15 set: flash, low byte returned
// - Indirect writes to flash ignored
// - Flash indirect read adds one cycle
// - 0x7000-0x70FF reads EEPROM, writes ignored
// - EEPROM indirect read adds one cycle
module sai_stack_indirect #(
   parameter DEPTH_W  = 4,
   parameter PC_W     = 15,
   parameter LIN_BANKS = 51
) (
   input  wire             clk_sys,
   input  wire             sys_rst,
   input  wire             stack_fault_reset_option,
   // Register port
   input  wire [7:0]       reg_addr,
   input  wire [7:0]       reg_wdata,
   input  wire             reg_wr,
   input  wire             reg_rd,
   output reg  [7:0]       reg_rdata,
   // Core stack operations
   input  wire             push_req,
   input  wire             pop_req,
   input  wire [PC_W-1:0]  push_pc,
   output reg  [PC_W-1:0]  pop_pc,
   output reg              stack_fault_reset,
   // Indirect access from the core
   input  wire             ind_req,
   input  wire             ind_sel,
   input  wire             ind_wr,
   input  wire [7:0]       ind_wdata,
   output wire             ind_stall,
   output reg              ind_done,
   output reg  [7:0]       ind_rdata,
   // Data memory side
   output reg              dmem_rd,
   output reg              dmem_wr,
   output reg  [12:0]      dmem_addr,
   output reg  [7:0]       dmem_wdata,
   input  wire [7:0]       dmem_rdata,
   // Flash and EEPROM read side
   output reg              flash_rd,
   output reg  [14:0]      flash_addr,
   input  wire [13:0]      flash_rdata,
   output reg              ee_rd,
   output reg  [7:0]       ee_addr,
   input  wire [7:0]       ee_rdata
);

   localparam RG_NONE  = 3'd0;
   localparam RG_BANK  = 3'd1;
   localparam RG_LIN   = 3'd2;
   localparam RG_FLASH = 3'd3;
   localparam RG_EE    = 3'd4;
   localparam RG_PORT  = 3'd5;

   localparam ST_IDLE  = 1'b0;
   localparam ST_WAIT  = 1'b1;

   reg [PC_W-1:0]  stk_mem_r [0:(1<<DEPTH_W)-1];
   reg [4:0]       sp_r;
   reg             ovf_r;
   reg             unf_r;
   reg [15:0]      fsp0_r;
   reg [15:0]      fsp1_r;
   reg             st_r;
   reg [2:0]       pend_rg_r;
   reg             pend_wr_r;
   integer         i;

   ////////////////////////////////////////////////////////////////////////////
   // Region decode
   function [2:0] region;
      input [15:0] a;
      begin
         if (a[`SAI_FLASH_BIT])
            region = RG_FLASH;
         // Port copies: bank 0 and bank 1 only
         else if (a[15:1] == 15'h0000 || a[15:1] == 15'h0040)
            region = RG_PORT;
         else if (a <= `SAI_BANKED_LAST)
            region = RG_BANK;
         else if (a >= `SAI_LIN_FIRST && a <= `SAI_LIN_LAST)
            region = RG_LIN;
         else if (a[15:8] == `SAI_EE_HI)
            region = RG_EE;
         else
            region = RG_NONE;
      end
   endfunction

   // Linear offset to bank and GENERAL_PURPOSE_RAM byte; common bytes never produced
   function [13:0] lin_map;
      input [15:0] a;
      reg   [11:0] off;
      reg   [11:0] quo;
      reg   [11:0] rem;
      reg   [6:0]  bank;
      reg   [6:0]  byt;
      begin
         off  = a[11:0];
         quo  = off / {5'h00, `SAI_GPR_SIZE};
         rem  = off % {5'h00, `SAI_GPR_SIZE};
         // Quotient stays below 51 inside the window
         bank = quo[6:0];
         byt  = rem[6:0];
         lin_map = {bank, byt + `SAI_GPR_BASE};
      end
   endfunction

   // Pointer, region and linear target of the selected port
   wire [15:0] ptr     = ind_sel ? fsp1_r : fsp0_r;
   wire [2:0]  rg      = region(ptr);
   wire [13:0] lin     = lin_map(ptr);
   wire        lin_ok  = lin[13:7] < LIN_BANKS;
   wire        slow    = ind_req && !ind_wr && (rg == RG_FLASH || rg == RG_EE);

   // First cycle of a slow read holds the core
   assign ind_stall = (st_r == ST_IDLE) && slow;

   ////////////////////////////////////////////////////////////////////////////
   // Indirect access
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         st_r <= ST_IDLE;
         pend_rg_r <= RG_NONE;
         pend_wr_r <= 1'b0;
         ind_done <= 1'b0;
         dmem_rd <= 1'b0;
         dmem_wr <= 1'b0;
         dmem_addr <= 13'h0000;
         dmem_wdata <= 8'h00;
         flash_rd <= 1'b0;
         flash_addr <= 15'h0000;
         ee_rd <= 1'b0;
         ee_addr <= 8'h00;
      end else begin
         ind_done <= 1'b0;
         dmem_rd <= 1'b0;
         dmem_wr <= 1'b0;
         flash_rd <= 1'b0;
         ee_rd <= 1'b0;
         case (st_r)
            ST_IDLE: begin
               if (ind_req) begin
                  pend_rg_r <= rg;
                  pend_wr_r <= ind_wr;
                  case (rg)
                     RG_BANK: begin
                        dmem_addr <= ptr[12:0];
                        dmem_rd <= !ind_wr;
                        dmem_wr <= ind_wr;
                        dmem_wdata <= ind_wdata;
                        ind_done <= 1'b1;
                     end
                     RG_LIN: begin
                        dmem_addr <= {lin[12:7], lin[6:0]};
                        dmem_rd <= !ind_wr && lin_ok;
                        dmem_wr <= ind_wr && lin_ok;
                        dmem_wdata <= ind_wdata;
                        ind_done <= 1'b1;
                        if (!lin_ok)
                           pend_rg_r <= RG_NONE;
                     end
                     RG_FLASH: begin
                        flash_addr <= ptr[14:0];
                        flash_rd <= !ind_wr;
                        ind_done <= ind_wr;
                        st_r <= ind_wr ? ST_IDLE : ST_WAIT;
                     end
                     RG_EE: begin
                        ee_addr <= ptr[7:0];
                        ee_rd <= !ind_wr;
                        ind_done <= ind_wr;
                        st_r <= ind_wr ? ST_IDLE : ST_WAIT;
                     end
                     default: begin
                        ind_done <= 1'b1;
                     end
                  endcase
               end
            end
            ST_WAIT: begin
               // Memory answered in the strobe cycle; release the core
               st_r <= ST_IDLE;
               ind_done <= 1'b1;
            end
            default: st_r <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Return stack
   wire        empty = (sp_r == `SAI_SP_RESET);
   wire        full  = (sp_r == `SAI_SP_TOP);
   wire [3:0]  sp_ix = sp_r[3:0];
   wire [4:0]  sp_inc = empty ? 5'h00 : ((sp_r + 5'h01) & 5'h0F);
   wire [4:0]  sp_dec = (empty || sp_r == 5'h00) ? `SAI_SP_RESET : (sp_r - 5'h01);
   wire [PC_W-1:0] tos = stk_mem_r[sp_ix];

   always @(posedge clk_sys) begin
      if (sys_rst) begin
         sp_r <= `SAI_SP_RESET;
         stack_fault_reset <= 1'b0;
         pop_pc <= {PC_W{1'b0}};
         for (i = 0; i < (1<<DEPTH_W); i = i + 1)
            stk_mem_r[i] <= {PC_W{1'b0}};
      end else begin
         stack_fault_reset <= 1'b0;
         // Push has priority; register writes lose to both
         // Fault reset leaves pointer and entries untouched
         if (push_req) begin
            if (full && stack_fault_reset_option)
               stack_fault_reset <= 1'b1;
            else begin
               sp_r <= sp_inc;
               stk_mem_r[sp_inc[3:0]] <= push_pc;
            end
         end else if (pop_req) begin
            if (empty && stack_fault_reset_option)
               stack_fault_reset <= 1'b1;
            else begin
               pop_pc <= tos;
               sp_r <= sp_dec;
            end
         end else if (reg_wr) begin
            case (reg_addr)
               `SAI_OFS_STK_PTR: sp_r <= reg_wdata[4:0];
               `SAI_OFS_TOS_LO: stk_mem_r[sp_ix] <= {tos[14:8], reg_wdata};
               `SAI_OFS_TOS_HI: stk_mem_r[sp_ix] <= {reg_wdata[6:0], tos[7:0]};
               default: ;
            endcase
         end
      end
   end

   // Flags survive the fault reset they trigger; software clears by writing one
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         ovf_r <= 1'b0;
         unf_r <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == `SAI_OFS_STK_STAT) begin
            if (reg_wdata[`SAI_ST_OVF_BIT]) ovf_r <= 1'b0;
            if (reg_wdata[`SAI_ST_UNF_BIT]) unf_r <= 1'b0;
         end
         // Set follows clear, so a same-cycle event wins
         if (push_req && full)
            ovf_r <= 1'b1;
         if (!push_req && pop_req && empty)
            unf_r <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register port
   // Stack top as software sees it
   reg [PC_W-1:0] tos_rd;
   always @* begin
      if (!empty)
         tos_rd = tos;
      else if (stack_fault_reset_option)
         tos_rd = {PC_W{1'b0}};
      else
         tos_rd = stk_mem_r[`SAI_EMPTY_ENTRY];
   end

   // Pointer bytes written one at a time; no carry between them
   always @(posedge clk_sys) begin
      if (sys_rst) begin
         fsp0_r <= 16'h0000;
         fsp1_r <= 16'h0000;
      end else if (reg_wr) begin
         case (reg_addr)
            `SAI_OFS_FSP0_LO: fsp0_r[7:0]  <= reg_wdata;
            `SAI_OFS_FSP0_HI: fsp0_r[15:8] <= reg_wdata;
            `SAI_OFS_FSP1_LO: fsp1_r[7:0]  <= reg_wdata;
            `SAI_OFS_FSP1_HI: fsp1_r[15:8] <= reg_wdata;
            default: ;
         endcase
      end
   end

   always @(posedge clk_sys) begin
      if (sys_rst)
         reg_rdata <= 8'h00;
      else if (reg_rd) begin
         case (reg_addr)
            `SAI_OFS_FSP0_LO:  reg_rdata <= fsp0_r[7:0];
            `SAI_OFS_FSP0_HI:  reg_rdata <= fsp0_r[15:8];
            `SAI_OFS_FSP1_LO:  reg_rdata <= fsp1_r[7:0];
            `SAI_OFS_FSP1_HI:  reg_rdata <= fsp1_r[15:8];
            `SAI_OFS_STK_PTR:  reg_rdata <= {3'b000, sp_r};
            `SAI_OFS_TOS_LO:   reg_rdata <= tos_rd[7:0];
            `SAI_OFS_TOS_HI:   reg_rdata <= {1'b0, tos_rd[14:8]};
            `SAI_OFS_STK_STAT: reg_rdata <= {6'h00, unf_r, ovf_r};
            default:           reg_rdata <= 8'h00;
         endcase
      end else
         reg_rdata <= 8'h00;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Indirect read data, registered with the done pulse
   reg [7:0] ind_mux;
   always @* begin
      case (pend_rg_r)
         RG_BANK, RG_LIN: ind_mux = dmem_rdata;
         RG_FLASH:        ind_mux = flash_rdata[7:0];
         RG_EE:           ind_mux = ee_rdata;
         default:         ind_mux = 8'h00;
      endcase
   end

   // Copy of the strobe-cycle data for the slow regions
   reg [7:0] ind_val_r;
   always @(posedge clk_sys) begin
      if (sys_rst)
         ind_val_r <= 8'h00;
      else
         ind_val_r <= ind_mux;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read data stands from the cycle after the done pulse
   reg [7:0] ind_rdata_nxt;
   always @* begin
      ind_rdata_nxt = ind_rdata;
      if (ind_done) begin
         if (pend_wr_r)
            ind_rdata_nxt = 8'h00;
         else begin
            case (pend_rg_r)
               // Slow reads: strobe cycle is gone, use the sampled copy
               RG_FLASH, RG_EE: ind_rdata_nxt = ind_val_r;
               default:         ind_rdata_nxt = ind_mux;
            endcase
         end
      end
   end

   always @(posedge clk_sys) begin
      if (sys_rst)
         ind_rdata <= 8'h00;
      else
         ind_rdata <= ind_rdata_nxt;
   end

endmodule // sai_stack_indirect

`default_nettype wire

// file: sai_regs.vh
// Register offsets, field positions and reset values for the stack and indirect unit.
// Assumes the core decodes the register port address into this small map.
`ifndef SAI_REGS_VH
`define SAI_REGS_VH

`define SAI_OFS_IND0      8'h00
`define SAI_OFS_IND1      8'h01
`define SAI_OFS_FSP0_LO   8'h04
`define SAI_OFS_FSP0_HI   8'h05
`define SAI_OFS_FSP1_LO   8'h06
`define SAI_OFS_FSP1_HI   8'h07
`define SAI_OFS_STK_PTR   8'h10
`define SAI_OFS_TOS_LO    8'h11
`define SAI_OFS_TOS_HI    8'h12
`define SAI_OFS_STK_STAT  8'h13

`define SAI_SP_RESET      5'h1F
`define SAI_SP_TOP        5'h0F
`define SAI_EMPTY_ENTRY   4'hF

`define SAI_BANKED_LAST   16'h1FFF
`define SAI_LIN_FIRST     16'h2000
`define SAI_LIN_LAST      16'h2FEF
`define SAI_EE_HI         8'h70
`define SAI_FLASH_BIT     15
`define SAI_GPR_SIZE      7'h50
`define SAI_GPR_BASE      7'h20
`define SAI_BANK_SIZE     8'h80

`define SAI_ST_OVF_BIT    0
`define SAI_ST_UNF_BIT    1

`endif

// file: sai_mem_model.sv
// Far-side memories: data RAM, program flash and EEPROM read ports.
// Assumes the unit samples read data while its read strobe is high.
`timescale 1ns/1ps
`default_nettype none
module sai_mem_model (
   input  wire logic        dmem_rd,
   input  wire logic [12:0] dmem_addr,
   output logic      [7:0]  dmem_rdata,
   input  wire logic        flash_rd,
   input  wire logic [14:0] flash_addr,
   output logic      [13:0] flash_rdata,
   input  wire logic        ee_rd,
   input  wire logic [7:0]  ee_addr,
   output logic      [7:0]  ee_rdata
);
   // Idle buses show the inverse so stale data cannot pass
   wire [7:0] dm_v = dmem_addr[7:0] ^ {3'b000, dmem_addr[12:8]};
   wire [7:0] fl_v = flash_addr[7:0] ^ 8'hC3;
   wire [7:0] ee_v = ee_addr + 8'h40;
   assign dmem_rdata  = dmem_rd ? dm_v : ~dm_v;
   assign flash_rdata = flash_rd ? {6'h3F, fl_v} : {6'h00, ~fl_v};
   assign ee_rdata    = ee_rd ? ee_v : ~ee_v;
endmodule // sai_mem_model
`default_nettype wire

// file: sai_stack_indirect_properties.sv
// Port-level checks for the stack and indirect unit.
// Assumes it is bound to the unit and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module sai_stack_indirect_chk #(
   parameter PC_W = 15
) (
   input wire logic            clk_sys,
   input wire logic            sys_rst,
   input wire logic            stack_fault_reset_option,
   input wire logic            reg_rd,
   input wire logic [7:0]      reg_rdata,
   input wire logic            push_req,
   input wire logic            pop_req,
   input wire logic [PC_W-1:0] pop_pc,
   input wire logic            stack_fault_reset,
   input wire logic            ind_req,
   input wire logic            ind_wr,
   input wire logic [7:0]      ind_wdata,
   input wire logic            ind_stall,
   input wire logic            ind_done,
   input wire logic            dmem_wr,
   input wire logic [7:0]      dmem_wdata,
   input wire logic            flash_rd,
   input wire logic            ee_rd
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (sys_rst);
   sequence slow_req; ind_req && ind_stall; endsequence
   sequence slow_ans; !ind_done ##1 ind_done; endsequence
   a_rd_data_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00) else $error("read data not idle");
   a_fault_cause: assert property (stack_fault_reset |-> $past(stack_fault_reset_option && (push_req || pop_req)))
      else $error("fault pulse without cause");
   a_no_fault_wrap: assert property (!stack_fault_reset_option && !$past(stack_fault_reset_option) |->
      !stack_fault_reset) else $error("fault pulse while wrapping");
   a_pop_pc_hold: assert property (!$past(pop_req) |-> $stable(pop_pc)) else $error("pop pc moved");
   a_slow_done: assert property (slow_req |=> slow_ans) else $error("slow read timing");
   a_fast_done: assert property (ind_req && !ind_stall |=> ind_done) else $error("fast access timing");
   a_stall_read_only: assert property (ind_stall |-> ind_req && !ind_wr) else $error("stall on write");
   a_flash_src: assert property (flash_rd |-> $past(ind_req && ind_stall)) else $error("stray flash read");
   a_ee_src: assert property (ee_rd |-> $past(ind_req && ind_stall)) else $error("stray eeprom read");
   a_dmem_wr_src: assert property (dmem_wr |-> $past(ind_req && ind_wr) && dmem_wdata == $past(ind_wdata))
      else $error("stray data write");
endmodule // sai_stack_indirect_chk
`default_nettype wire

// file: tb_sai_stack_indirect.sv
// Self-checking bench: bench plays the core, model plays the memories.
// Assumes the unit's register map header and one-cycle read answers.
`timescale 1ns/1ps
`default_nettype none
`include "sai_regs.vh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end
module tb_sai_stack_indirect;
   logic clk_sys = 0, sys_rst = 1, opt = 0, reg_wr = 0, reg_rd = 0, push_req = 0, pop_req = 0;
   logic ind_req = 0, ind_sel = 0, ind_wr = 0, stack_fault_reset, ind_stall, ind_done;
   logic dmem_rd, dmem_wr, flash_rd, ee_rd;
   logic [7:0] reg_addr = 0, reg_wdata = 0, ind_wdata = 8'hA5, reg_rdata, ind_rdata, dmem_addr_lo;
   logic [7:0] dmem_wdata, dmem_rdata, ee_addr, ee_rdata, last_wd;
   logic [14:0] push_pc = 0, pop_pc, flash_addr;
   logic [12:0] dmem_addr, last_wa;
   logic [13:0] flash_rdata;
   int num_errors = 0, n_checks = 0, flt_cnt = 0, wr_cnt = 0;
   // Fewer linear banks so a hole exists inside the linear window
   sai_stack_indirect #(.LIN_BANKS(40)) dut_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
      .stack_fault_reset_option(opt), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_rdata(reg_rdata), .push_req(push_req), .pop_req(pop_req), .push_pc(push_pc),
      .pop_pc(pop_pc), .stack_fault_reset(stack_fault_reset), .ind_req(ind_req), .ind_sel(ind_sel),
      .ind_wr(ind_wr), .ind_wdata(ind_wdata), .ind_stall(ind_stall), .ind_done(ind_done),
      .ind_rdata(ind_rdata), .dmem_rd(dmem_rd), .dmem_wr(dmem_wr), .dmem_addr(dmem_addr),
      .dmem_wdata(dmem_wdata), .dmem_rdata(dmem_rdata), .flash_rd(flash_rd), .flash_addr(flash_addr),
      .flash_rdata(flash_rdata), .ee_rd(ee_rd), .ee_addr(ee_addr), .ee_rdata(ee_rdata));
   sai_mem_model mem_u (.dmem_rd(dmem_rd), .dmem_addr(dmem_addr), .dmem_rdata(dmem_rdata),
      .flash_rd(flash_rd), .flash_addr(flash_addr), .flash_rdata(flash_rdata), .ee_rd(ee_rd),
      .ee_addr(ee_addr), .ee_rdata(ee_rdata));
   always #2 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (stack_fault_reset === 1'b1) flt_cnt <= flt_cnt + 1;
      if (dmem_wr === 1'b1) begin
         wr_cnt <= wr_cnt + 1;
         last_wa <= dmem_addr;
         last_wd <= dmem_wdata;
      end
   end
   function automatic [14:0] pcv(input int i);
      pcv = 15'h0A00 + 15'(i) * 15'h0123;
   endfunction
   function automatic [7:0] dm(input [12:0] a);
      dm = a[7:0] ^ {3'b000, a[12:8]};
   endfunction
   ////////////////////////////////////////////////////////////////////////
   task automatic rst(input logic o);
      @(posedge clk_sys) begin sys_rst <= 1; opt <= o; end
      repeat (10) @(posedge clk_sys);
      sys_rst <= 0;
   endtask
   task automatic reg_w(input [7:0] a, input [7:0] d);
      @(posedge clk_sys) begin reg_wr <= 1; reg_addr <= a; reg_wdata <= d; end
      @(posedge clk_sys) reg_wr <= 0;
   endtask
   task automatic reg_r(input [7:0] a, input [7:0] e);
      @(posedge clk_sys) begin reg_rd <= 1; reg_addr <= a; end
      @(posedge clk_sys) reg_rd <= 0;
      #1 `CHK(reg_rdata, e)
   endtask
   task automatic stk(input logic push, input [14:0] pc);
      @(posedge clk_sys) begin push_req <= push; pop_req <= !push; push_pc <= pc; end
      @(posedge clk_sys) begin push_req <= 0; pop_req <= 0; end
      @(posedge clk_sys) #1;
   endtask
   task automatic tos(input [14:0] pc);
      reg_r(`SAI_OFS_TOS_LO, pc[7:0]);
      reg_r(`SAI_OFS_TOS_HI, {1'b0, pc[14:8]});
   endtask
   task automatic ind_op(input logic s, input [15:0] p, input logic w, input [7:0] e, input logic slow);
      logic st;
      int k;
      reg_w(s ? `SAI_OFS_FSP1_LO : `SAI_OFS_FSP0_LO, p[7:0]);
      reg_w(s ? `SAI_OFS_FSP1_HI : `SAI_OFS_FSP0_HI, p[15:8]);
      @(posedge clk_sys) begin ind_req <= 1; ind_sel <= s; ind_wr <= w; end
      #1 st = ind_stall;
      k = 0;
      do begin
         @(posedge clk_sys) ind_req <= 0;
         #1 k++;
      end while (ind_done !== 1'b1 && k < 8);
      `CHK(k, slow ? 2 : 1)
      `CHK(st, slow)
      @(posedge clk_sys) #1;
      if (!w) `CHK(ind_rdata, e)
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      #200000 num_errors++;
      end_of_test;
   end
   initial begin
      rst(1);
      reg_r(`SAI_OFS_STK_PTR, 8'h1F);
      tos(15'h0000);
      reg_r(`SAI_OFS_STK_STAT, 8'h00);
      stk(0, 0);
      `CHK(flt_cnt, 1)
      reg_r(`SAI_OFS_STK_STAT, 8'h02);
      for (int i = 0; i < 16; i++) stk(1, pcv(i));
      reg_r(`SAI_OFS_STK_PTR, 8'h0F);
      stk(1, pcv(16));
      `CHK(flt_cnt, 2)
      reg_r(`SAI_OFS_STK_STAT, 8'h03);
      reg_w(`SAI_OFS_STK_STAT, 8'h02);
      reg_r(`SAI_OFS_STK_STAT, 8'h01);
      rst(0);
      reg_r(`SAI_OFS_STK_STAT, 8'h00);
      for (int i = 0; i < 16; i++) stk(1, pcv(i));
      for (int i = 15; i >= 0; i--) begin
         stk(0, 0);
         `CHK(pop_pc, pcv(i))
      end
      reg_r(`SAI_OFS_STK_PTR, 8'h1F);
      tos(pcv(15));
      for (int i = 0; i < 17; i++) stk(1, pcv(i));
      reg_r(`SAI_OFS_STK_PTR, 8'h00);
      tos(pcv(16));
      reg_r(`SAI_OFS_STK_STAT, 8'h01);
      `CHK(flt_cnt, 2)
      reg_w(`SAI_OFS_STK_PTR, 8'h05);
      tos(pcv(5));
      stk(0, 0);
      `CHK(pop_pc, pcv(5))
      reg_r(`SAI_OFS_STK_PTR, 8'h04);
      ind_op(0, 16'h1234, 0, dm(13'h1234), 0);
      ind_op(1, 16'h2051, 0, dm(13'h00A1), 0);
      ind_op(0, 16'h2C7F, 0, dm(13'h13EF), 0);
      ind_op(1, 16'h2C80, 0, 8'h00, 0);
      ind_op(0, 16'h3000, 0, 8'h00, 0);
      ind_op(1, 16'h0001, 0, 8'h00, 0);
      ind_op(0, 16'h8005, 0, 8'hC6, 1);
      ind_op(1, 16'hF005, 0, 8'hC6, 1);
      ind_op(0, 16'h7012, 0, 8'h52, 1);
      ind_op(1, 16'h0081, 1, 8'h00, 0);
      ind_op(0, 16'h8005, 1, 8'h00, 0);
      ind_op(1, 16'h7012, 1, 8'h00, 0);
      `CHK(wr_cnt, 0)
      ind_op(0, 16'h0100, 1, 8'h00, 0);
      `CHK(wr_cnt, 1)
      `CHK(last_wa, 13'h0100)
      `CHK(last_wd, 8'hA5)
      end_of_test;
   end
endmodule // tb_sai_stack_indirect
bind sai_stack_indirect sai_stack_indirect_chk #(.PC_W(PC_W)) chk_u (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .stack_fault_reset_option(stack_fault_reset_option), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .push_req(push_req), .pop_req(pop_req), .pop_pc(pop_pc), .stack_fault_reset(stack_fault_reset),
   .ind_req(ind_req), .ind_wr(ind_wr), .ind_wdata(ind_wdata), .ind_stall(ind_stall), .ind_done(ind_done),
   .dmem_wr(dmem_wr), .dmem_wdata(dmem_wdata), .flash_rd(flash_rd), .ee_rd(ee_rd));
`default_nettype wire
